/* File: pkg/mcit_pkg.sv */
package mcit_pkg;
  // operand addressing classes
  typedef enum logic [2:0] {
    MCIT_OP_NONE, MCIT_OP_WREG, MCIT_OP_IND, MCIT_OP_DIR, MCIT_OP_IMM, MCIT_OP_DATA_POINTER16
  } mcit_opnd_t;
  // instruction length in bytes and cycles
  localparam logic [1:0] MCIT_LEN1 = 2'h1;
  localparam logic [1:0] MCIT_LEN2 = 2'h2;
  localparam logic [1:0] MCIT_LEN3 = 2'h3;
  localparam logic [3:0] MCIT_CYC1 = 4'h1;
  localparam logic [3:0] MCIT_CYC2 = 4'h2;
  localparam logic [3:0] MCIT_CYC3 = 4'h3;
  localparam logic [3:0] MCIT_CYC4 = 4'h4;
  localparam logic [3:0] MCIT_CYC8 = 4'h8;
  // stack pointer reset value
  localparam logic [7:0] MCIT_SP_RESET = 8'h07;
  // direct space split: bit 7 set selects special function registers
  localparam int MCIT_DIR_SFR_BIT = 7;
  // working register bank select position in status word
  localparam int MCIT_BANK_LSB = 3;
  // index register select bit, register number field
  localparam int MCIT_IDX_BIT = 0;
  localparam logic [7:0] MCIT_ONE = 8'h01;
endpackage

/* File: rtl/mcit_core.sv */
`timescale 1ns/10ps
// Overview of operation
// RQ1 - external move may also write or erase flash; the core only raises o_flash_wr, it has no erase
// RQ2 - register arithmetic: one byte, one cycle
// RQ3 - indirect ram operands: one byte, two cycles
// RQ4 - direct/immediate accumulator ops: two bytes, two cycles
// RQ5 - immediate into direct logic: three bytes, three
// RQ6 - accumulator rotates: one byte, one cycle
// RQ7 - direct to direct move: three, three
// RQ8 - data pointer constant load: three, three
// RQ9 - code byte read: one byte, three cycles
// RQ10 - index external move: one byte, three cycles
// RQ11 - pointer external move: one byte, three cycles
// RQ12 - push and pop: two bytes, two cycles
// RQ13 - low nibble exchange: one byte, two
// RQ14 - immediate into indirect: two bytes, two
// RQ15 - working register: one of eight in bank
// RQ16 - direct address: low ram, high sfr
// RQ17 - stack pointer pre-increments on push, resets 07
// RQ18 - next fetch held until cycle count elapses
module mcit_core (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // instruction issue
  input wire logic i_valid,
  input wire logic [7:0] i_opcode,
  input wire logic [7:0] i_operand1,
  input wire logic [1:0] i_bank_sel,
  input wire logic [7:0] i_index_r0,
  input wire logic [7:0] i_index_r1,
  input wire logic [15:0] i_data_pointer16,
  input wire logic i_flash_sel,
  // issue handshake and state
  output logic o_ready,
  output logic o_busy,
  output logic o_done,
  output logic [1:0] o_len,
  output logic [3:0] o_cycles,
  // memory access strobes
  output logic [7:0] o_ram_addr,
  output logic o_ram_sel,
  output logic o_sfr_sel,
  output logic [15:0] o_ext_addr,
  output logic o_ext_rd,
  output logic o_ext_wr,
  output logic o_flash_wr,
  output logic o_code_rd,
  output logic o_nib_xchg,
  output logic [7:0] o_stack_pointer
);
  // decoder outputs
  logic [1:0] dec_len;
  logic [3:0] dec_cyc;
  mcit_pkg::mcit_opnd_t dec_opnd;
  logic dec_ext;
  logic dec_extw;
  logic dec_code;
  logic dec_push;
  logic dec_pop;
  logic dec_nib;
  logic take; // new instruction accepted

  // opcode table
  mcit_decode u_decode (
    .i_opcode(i_opcode),
    .o_len(dec_len),
    .o_cycles(dec_cyc),
    .o_opnd(dec_opnd),
    .o_ext_move(dec_ext),
    .o_ext_write(dec_extw),
    .o_code_read(dec_code),
    .o_push(dec_push),
    .o_pop(dec_pop),
    .o_nib_xchg(dec_nib)
  );

  // state registers
  logic [3:0] cnt_reg, cnt_next; // remaining cycles
  logic done_reg, done_next;
  logic [1:0] len_reg, len_next;
  logic [3:0] cyc_reg, cyc_next;
  logic [7:0] addr_reg, addr_next;
  logic ram_reg, ram_next;
  logic sfr_reg, sfr_next;
  logic [15:0] ext_reg, ext_next;
  logic rd_reg, rd_next;
  logic wr_reg, wr_next;
  logic fl_reg, fl_next;
  logic code_reg, code_next;
  logic nib_reg, nib_next;
  logic [7:0] sp_reg, sp_next;
  logic [7:0] idx; // selected index register
  logic [7:0] wreg_addr; // bank-relative register address

  // next fetch only when idle
  assign o_ready = (cnt_reg == 4'h0); // RQ18
  assign take = i_valid & o_ready;
  assign idx = i_opcode[mcit_pkg::MCIT_IDX_BIT] ? i_index_r1 : i_index_r0;
  assign wreg_addr = {3'h0, i_bank_sel, i_opcode[2:0]}; // RQ15

  // next state
  always_comb
  begin
    cnt_next = cnt_reg;
    done_next = 1'b0;
    len_next = len_reg;
    cyc_next = cyc_reg;
    addr_next = addr_reg;
    ram_next = ram_reg;
    sfr_next = sfr_reg;
    ext_next = ext_reg;
    rd_next = rd_reg;
    wr_next = wr_reg;
    fl_next = fl_reg;
    code_next = code_reg;
    nib_next = nib_reg;
    sp_next = sp_reg;
    if (cnt_reg != 4'h0)
    begin
      // count down; last cycle flags completion
      cnt_next = cnt_reg - 4'h1; // RQ18
      done_next = (cnt_reg == 4'h1);
      if (cnt_reg == 4'h1)
      begin
        // drop strobes at end of a multi-cycle instruction; a one-cycle one keeps them until the next take
        ram_next = 1'b0;
        sfr_next = 1'b0;
        rd_next = 1'b0;
        wr_next = 1'b0;
        fl_next = 1'b0;
        code_next = 1'b0;
        nib_next = 1'b0;
      end
    end
    if (take)
    begin
      // hold busy for the listed count, including this cycle
      cnt_next = dec_cyc - 4'h1; // RQ18
      done_next = (dec_cyc == mcit_pkg::MCIT_CYC1);
      len_next = dec_len;
      cyc_next = dec_cyc;
      ram_next = 1'b0;
      sfr_next = 1'b0;
      rd_next = dec_ext & ~dec_extw;
      wr_next = dec_ext & dec_extw & ~i_flash_sel;
      fl_next = dec_ext & dec_extw & i_flash_sel; // RQ1
      code_next = dec_code; // RQ9
      nib_next = dec_nib; // RQ13
      ext_next = (dec_opnd == mcit_pkg::MCIT_OP_DATA_POINTER16) ? i_data_pointer16 : {8'h00, idx}; // RQ10 RQ11
      case (dec_opnd)
        mcit_pkg::MCIT_OP_WREG:
        begin
          addr_next = wreg_addr;
          ram_next = 1'b1;
        end
        mcit_pkg::MCIT_OP_IND:
        begin
          addr_next = idx;
          ram_next = ~dec_ext;
        end
        mcit_pkg::MCIT_OP_DIR:
        begin
          addr_next = i_operand1;
          sfr_next = i_operand1[mcit_pkg::MCIT_DIR_SFR_BIT]; // RQ16
          ram_next = ~i_operand1[mcit_pkg::MCIT_DIR_SFR_BIT]; // RQ16
        end
        default:
        begin
          addr_next = addr_reg;
        end
      endcase
      if (dec_push)
      begin
        // pre-increment the stack pointer on a push
        sp_next = sp_reg + mcit_pkg::MCIT_ONE; // RQ17
      end
      else if (dec_pop)
      begin
        sp_next = sp_reg - mcit_pkg::MCIT_ONE;
      end
    end
  end

  // registers
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      cnt_reg <= 4'h0;
      done_reg <= 1'b0;
      len_reg <= 2'h0;
      cyc_reg <= 4'h0;
      addr_reg <= 8'h00;
      ram_reg <= 1'b0;
      sfr_reg <= 1'b0;
      ext_reg <= 16'h0000;
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      fl_reg <= 1'b0;
      code_reg <= 1'b0;
      nib_reg <= 1'b0;
      sp_reg <= mcit_pkg::MCIT_SP_RESET; // RQ17
    end
    else
    begin
      cnt_reg <= cnt_next;
      done_reg <= done_next;
      len_reg <= len_next;
      cyc_reg <= cyc_next;
      addr_reg <= addr_next;
      ram_reg <= ram_next;
      sfr_reg <= sfr_next;
      ext_reg <= ext_next;
      rd_reg <= rd_next;
      wr_reg <= wr_next;
      fl_reg <= fl_next;
      code_reg <= code_next;
      nib_reg <= nib_next;
      sp_reg <= sp_next;
    end
  end

  // outputs
  assign o_busy = (cnt_reg != 4'h0);
  assign o_done = done_reg;
  assign o_len = len_reg;
  assign o_cycles = cyc_reg;
  assign o_ram_addr = addr_reg;
  assign o_ram_sel = ram_reg;
  assign o_sfr_sel = sfr_reg;
  assign o_ext_addr = ext_reg;
  assign o_ext_rd = rd_reg;
  assign o_ext_wr = wr_reg;
  assign o_flash_wr = fl_reg;
  assign o_code_rd = code_reg;
  assign o_nib_xchg = nib_reg;
  assign o_stack_pointer = sp_reg;

  // checks
  chk_no_overlap: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ18
    take && dec_cyc == 4'h3 |=> !o_ready ##1 !o_ready ##1 o_ready)
    else $error("next fetch allowed too early");
  chk_reg_one_cycle: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ2
    take && i_opcode[7:4] == 4'h2 && i_opcode[3] |=> o_ready && o_done && o_len == 2'h1)
    else $error("register add not one cycle");
  chk_ind_two: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ3
    take && i_opcode == 8'h26 |=> o_cycles == 4'h2 && o_len == 2'h1 ##1 o_done)
    else $error("indirect add wrong timing");
  chk_imm_two: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ4
    take && i_opcode == 8'h24 |=> o_len == 2'h2 && o_cycles == 4'h2)
    else $error("immediate add wrong length");
  chk_dir_imm: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ5
    take && i_opcode == 8'h53 |=> o_len == 2'h3 && o_cycles == 4'h3)
    else $error("immediate into direct wrong");
  chk_movdd: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ7
    take && i_opcode == 8'h85 |=> o_len == 2'h3 ##2 o_done)
    else $error("direct move wrong timing");
  chk_flash_wr: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ1
    take && i_opcode == 8'hf0 && i_flash_sel |=> o_flash_wr && !o_ext_wr)
    else $error("flash write not issued");
  chk_push_sp: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ17
    take && i_opcode == 8'hc0 |=> o_stack_pointer == $past(o_stack_pointer) + 8'h01)
    else $error("push did not pre-increment");
  chk_sfr_sel: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ16
    take && i_opcode == 8'he5 |=> o_sfr_sel == $past(i_operand1[7]) && o_ram_sel != o_sfr_sel)
    else $error("direct space split wrong");
endmodule

/* File: rtl/mcit_decode.sv */
`timescale 1ns/10ps
// combinational opcode table: length, cycle count and operand class
module mcit_decode (
  // opcode in
  input wire logic [7:0] i_opcode,
  // decoded attributes
  output logic [1:0] o_len,
  output logic [3:0] o_cycles,
  output mcit_pkg::mcit_opnd_t o_opnd,
  output logic o_ext_move,
  output logic o_ext_write,
  output logic o_code_read,
  output logic o_push,
  output logic o_pop,
  output logic o_nib_xchg
);
  logic [3:0] lo; // low nibble
  logic [3:0] hi; // high nibble
  assign lo = i_opcode[3:0];
  assign hi = i_opcode[7:4];

  // table lookup by opcode pattern
  always_comb
  begin
    o_len = mcit_pkg::MCIT_LEN1;
    o_cycles = mcit_pkg::MCIT_CYC1;
    o_opnd = mcit_pkg::MCIT_OP_NONE;
    o_ext_move = 1'b0;
    o_ext_write = 1'b0;
    o_code_read = 1'b0;
    o_push = 1'b0;
    o_pop = 1'b0;
    o_nib_xchg = 1'b0;
    // arithmetic / logic / move group by low nibble
    if (lo[3])
    begin
      // working register forms: one byte, one cycle; two bytes, two cycles for high nibble 7, 8, a, b and d
      o_opnd = mcit_pkg::MCIT_OP_WREG; // RQ15
      if (hi == 4'h8 || hi == 4'ha)
      begin
        // direct<->register moves: two bytes
        o_len = mcit_pkg::MCIT_LEN2;
        o_cycles = mcit_pkg::MCIT_CYC2;
      end
      else if (hi == 4'h7)
      begin
        // immediate into register
        o_len = mcit_pkg::MCIT_LEN2;
        o_cycles = mcit_pkg::MCIT_CYC2;
      end
      else if (hi == 4'hb || hi == 4'hd)
      begin
        // branch forms belong elsewhere
        o_len = mcit_pkg::MCIT_LEN2;
        o_cycles = mcit_pkg::MCIT_CYC2;
      end
      else
      begin
        o_len = mcit_pkg::MCIT_LEN1; // RQ2
        o_cycles = mcit_pkg::MCIT_CYC1; // RQ2
      end
    end
    else if (lo[3:1] == 3'h3)
    begin
      // indirect ram operand: one byte, two cycles; two bytes for high nibble 7, 8 and a
      o_opnd = mcit_pkg::MCIT_OP_IND;
      o_len = mcit_pkg::MCIT_LEN1; // RQ3
      o_cycles = mcit_pkg::MCIT_CYC2; // RQ3
      if (hi == 4'h7 || hi == 4'h8 || hi == 4'ha)
      begin
        // immediate or direct into indirect location
        o_len = mcit_pkg::MCIT_LEN2; // RQ14
      end
      if (hi == 4'hd)
      begin
        o_nib_xchg = 1'b1; // RQ13
      end
    end
    else if (lo == 4'h5)
    begin
      // direct operand: two bytes two cycles, three bytes three cycles for high nibble 7 and 8
      o_opnd = mcit_pkg::MCIT_OP_DIR;
      o_len = mcit_pkg::MCIT_LEN2; // RQ4
      o_cycles = mcit_pkg::MCIT_CYC2; // RQ4
      if (hi == 4'h8)
      begin
        // direct to direct move
        o_len = mcit_pkg::MCIT_LEN3; // RQ7
        o_cycles = mcit_pkg::MCIT_CYC3; // RQ7
      end
      else if (hi == 4'h7)
      begin
        // immediate into direct byte: three bytes three cycles
        o_len = mcit_pkg::MCIT_LEN3;
        o_cycles = mcit_pkg::MCIT_CYC3;
      end
    end
    else if (lo == 4'h4)
    begin
      // immediate or accumulator-only forms
      o_opnd = mcit_pkg::MCIT_OP_IMM;
      if (hi >= 4'h2 && hi <= 4'h7 || hi == 4'h9)
      begin
        o_len = mcit_pkg::MCIT_LEN2; // RQ4
        o_cycles = mcit_pkg::MCIT_CYC2; // RQ4
      end
      else if (hi == 4'ha)
      begin
        o_cycles = mcit_pkg::MCIT_CYC4;
      end
      else if (hi == 4'h8)
      begin
        o_cycles = mcit_pkg::MCIT_CYC8;
      end
      else if (hi == 4'hf)
      begin
        o_cycles = mcit_pkg::MCIT_CYC2;
      end
      else
      begin
        // inc, dec, swap, clr, da: one byte one cycle
        o_opnd = mcit_pkg::MCIT_OP_NONE;
        o_cycles = mcit_pkg::MCIT_CYC1; // RQ2
      end
    end
    else if (lo[3:1] == 3'h1 && (hi == 4'he || hi == 4'hf))
    begin
      // external move with 8-bit index address, no ram access
      o_opnd = mcit_pkg::MCIT_OP_IND;
      o_ext_move = 1'b1; // RQ10
      o_ext_write = hi[0];
      o_cycles = mcit_pkg::MCIT_CYC3; // RQ10
    end
    else if (lo == 4'h3 && hi >= 4'h4 && hi <= 4'h6)
    begin
      // logic immediate into direct byte
      o_opnd = mcit_pkg::MCIT_OP_DIR;
      o_len = mcit_pkg::MCIT_LEN3; // RQ5
      o_cycles = mcit_pkg::MCIT_CYC3; // RQ5
    end
    else if (lo == 4'h2 && hi >= 4'h4 && hi <= 4'h6)
    begin
      // logic accumulator into direct byte
      o_opnd = mcit_pkg::MCIT_OP_DIR;
      o_len = mcit_pkg::MCIT_LEN2;
      o_cycles = mcit_pkg::MCIT_CYC2;
    end
    else if (lo == 4'h3 && (hi == 4'h8 || hi == 4'h9))
    begin
      // code byte read, pc or data pointer relative
      o_code_read = 1'b1;
      o_len = mcit_pkg::MCIT_LEN1; // RQ9
      o_cycles = mcit_pkg::MCIT_CYC3; // RQ9
    end
    else if (lo == 4'h3 && hi == 4'ha)
    begin
      // increment data pointer
      o_opnd = mcit_pkg::MCIT_OP_DATA_POINTER16;
    end
    else if (lo == 4'h0 && (hi == 4'he || hi == 4'hf))
    begin
      // external move via 16-bit data pointer
      o_opnd = mcit_pkg::MCIT_OP_DATA_POINTER16;
      o_ext_move = 1'b1; // RQ11
      o_ext_write = hi[0];
      o_cycles = mcit_pkg::MCIT_CYC3; // RQ11
    end
    else if (lo == 4'h0 && (hi == 4'hc || hi == 4'hd))
    begin
      // stack push or pop of a direct byte
      o_opnd = mcit_pkg::MCIT_OP_DIR;
      o_push = ~hi[0];
      o_pop = hi[0];
      o_len = mcit_pkg::MCIT_LEN2; // RQ12
      o_cycles = mcit_pkg::MCIT_CYC2; // RQ12
    end
    else if (lo == 4'h0 && hi == 4'h9)
    begin
      // load data pointer with constant
      o_opnd = mcit_pkg::MCIT_OP_DATA_POINTER16;
      o_len = mcit_pkg::MCIT_LEN3; // RQ8
      o_cycles = mcit_pkg::MCIT_CYC3; // RQ8
    end
    else if (lo == 4'h3 && (hi == 4'h0 || hi == 4'h1 || hi == 4'h2 || hi == 4'h3))
    begin
      // accumulator rotates with or without carry
      o_len = mcit_pkg::MCIT_LEN1; // RQ6
      o_cycles = mcit_pkg::MCIT_CYC1; // RQ6
    end
  end
endmodule

/* File: tb/mcit_core_tb.sv */
`timescale 1ns/10ps
// self-checking bench for the instruction timing core
module mcit_core_tb;
  // core stimulus
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic i_valid = 1'b0;
  logic [7:0] i_opcode = 8'h00;
  logic [7:0] i_operand1 = 8'h00;
  logic [1:0] i_bank_sel = 2'h0;
  logic [7:0] i_index_r0 = 8'h00;
  logic [7:0] i_index_r1 = 8'h00;
  logic [15:0] i_data_pointer16 = 16'h0000;
  logic i_flash_sel = 1'b0;
  // core outputs
  logic o_ready, o_busy, o_done, o_ram_sel, o_sfr_sel;
  logic o_ext_rd, o_ext_wr, o_flash_wr, o_code_rd, o_nib_xchg;
  logic [1:0] o_len;
  logic [3:0] o_cycles;
  logic [7:0] o_ram_addr, o_stack_pointer;
  logic [15:0] o_ext_addr;
  // model tallies
  logic [7:0] flash_cnt, ext_cnt;
  logic [15:0] flash_addr;
  logic sel_clash;
  // first-cycle snapshot of access outputs
  logic [7:0] c_ram_addr;
  logic [1:0] c_sel;
  logic [15:0] c_ext_addr;
  logic [4:0] c_acc;
  // result counters
  int mismatches = 0;
  int cmp_count = 0;
  // opcode table: opcode, bytes, cycles
  localparam logic [7:0] OPS [29] = '{8'h28, 8'h38, 8'h98, 8'h08, 8'h18, 8'h26, 8'h57,
    8'h25, 8'h24, 8'h54, 8'h53, 8'h43, 8'h63, 8'h23, 8'h33, 8'h03, 8'h13, 8'h85, 8'h90,
    8'h93, 8'h83, 8'he2, 8'hf3, 8'he0, 8'hf0, 8'hc0, 8'hd0, 8'hd6, 8'h76};
  localparam logic [1:0] LENS [29] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2,
    2'h2, 2'h2, 2'h3, 2'h3, 2'h3, 2'h1, 2'h1, 2'h1, 2'h1, 2'h3, 2'h3, 2'h1, 2'h1, 2'h1,
    2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h1, 2'h2};
  localparam logic [3:0] CYCS [29] = '{4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h2, 4'h2, 4'h2,
    4'h2, 4'h2, 4'h3, 4'h3, 4'h3, 4'h1, 4'h1, 4'h1, 4'h1, 4'h3, 4'h3, 4'h3, 4'h3, 4'h3,
    4'h3, 4'h3, 4'h3, 4'h2, 4'h2, 4'h2, 4'h2};

  // free-running system clock
  always #5 i_mclk = ~i_mclk;

  mcit_core u_mcit_core (.i_mclk(i_mclk), .i_rst(i_rst), .i_valid(i_valid),
    .i_opcode(i_opcode), .i_operand1(i_operand1), .i_bank_sel(i_bank_sel),
    .i_index_r0(i_index_r0), .i_index_r1(i_index_r1), .i_data_pointer16(i_data_pointer16),
    .i_flash_sel(i_flash_sel), .o_ready(o_ready), .o_busy(o_busy), .o_done(o_done),
    .o_len(o_len), .o_cycles(o_cycles), .o_ram_addr(o_ram_addr), .o_ram_sel(o_ram_sel),
    .o_sfr_sel(o_sfr_sel), .o_ext_addr(o_ext_addr), .o_ext_rd(o_ext_rd),
    .o_ext_wr(o_ext_wr), .o_flash_wr(o_flash_wr), .o_code_rd(o_code_rd),
    .o_nib_xchg(o_nib_xchg), .o_stack_pointer(o_stack_pointer));

  mcit_mem_model u_mcit_mem_model (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_ext_addr(o_ext_addr), .i_ext_wr(o_ext_wr), .i_flash_wr(o_flash_wr),
    .i_ram_sel(o_ram_sel), .i_sfr_sel(o_sfr_sel), .o_flash_wr_cnt(flash_cnt),
    .o_ext_wr_cnt(ext_cnt), .o_last_flash_addr(flash_addr), .o_sel_clash(sel_clash));

  // one comparison, reported at once on a miss
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  // issue one instruction, check length, count, done and ready per cycle
  task automatic run_op(input logic [7:0] op, input logic [7:0] opd,
    input logic [1:0] len, input logic [3:0] cyc);
    int k;
    @(posedge i_mclk);
    i_valid <= 1'b1;
    i_opcode <= op;
    i_operand1 <= opd;
    @(posedge i_mclk);
    i_valid <= 1'b0;
    // first look falls in the cycle right after the taking edge
    for (k = 1; k <= cyc; k++)
    begin
      if (k > 1)
        @(posedge i_mclk);
      #1;
      // access outputs stand from the first cycle
      if (k == 1)
      begin
        chk(o_len, len, "bytes");
        chk(o_cycles, cyc, "cycles");
        c_ram_addr = o_ram_addr;
        c_sel = {o_ram_sel, o_sfr_sel};
        c_ext_addr = o_ext_addr;
        c_acc = {o_ext_rd, o_ext_wr, o_flash_wr, o_code_rd, o_nib_xchg};
      end
      chk(o_done, k == cyc, "done");
      chk(o_ready, k == cyc, "ready");
      chk(o_busy, k != cyc, "busy");
    end
  endtask

  // every timing class of the table except the 4- and 8-cycle forms, which are never run
  task automatic test_table();
    int i;
    for (i = 0; i < 29; i++)
      run_op(OPS[i], 8'h30, LENS[i], CYCS[i]);
  endtask

  // working register address follows the bank bits
  task automatic test_bank();
    int b;
    for (b = 0; b < 4; b++)
    begin
      @(posedge i_mclk);
      i_bank_sel <= b[1:0];
      run_op(8'h0f, 8'h00, 2'h1, 4'h1);
      chk(c_ram_addr, 8'h07 + 8'(b * 8), "bank reg addr");
      chk(c_sel, 2'b10, "bank reg space");
    end
  endtask

  // lower direct half is ram, upper half is sfr
  task automatic test_direct();
    run_op(8'he5, 8'h7f, 2'h2, 4'h2);
    chk(c_sel, 2'b10, "direct 7f space");
    chk(c_ram_addr, 8'h7f, "direct 7f addr");
    run_op(8'he5, 8'h80, 2'h2, 4'h2);
    chk(c_sel, 2'b01, "direct 80 space");
    chk(sel_clash, 1'b0, "ram and sfr together");
  endtask

  // indirect, external, flash and code accesses
  task automatic test_access();
    logic [7:0] f0;
    logic [7:0] e0;
    f0 = flash_cnt;
    e0 = ext_cnt;
    @(posedge i_mclk);
    i_index_r1 <= 8'h44;
    i_index_r0 <= 8'h5a;
    i_data_pointer16 <= 16'h1234;
    run_op(8'hd7, 8'h00, 2'h1, 4'h2);
    chk(c_ram_addr, 8'h44, "nibble addr");
    chk(c_acc, 5'b00001, "nibble strobe");
    run_op(8'hf2, 8'h00, 2'h1, 4'h3);
    chk(c_ext_addr, 16'h005a, "index ext addr");
    chk(c_acc, 5'b01000, "index ext write");
    chk(ext_cnt, e0 + 8'h01, "ext write count");
    run_op(8'he0, 8'h00, 2'h1, 4'h3);
    chk(c_ext_addr, 16'h1234, "pointer ext addr");
    chk(c_acc[4], 1'b1, "pointer ext read");
    run_op(8'h93, 8'h00, 2'h1, 4'h3);
    chk(c_acc[1], 1'b1, "code read");
    @(posedge i_mclk);
    i_flash_sel <= 1'b1;
    run_op(8'hf0, 8'h00, 2'h1, 4'h3);
    @(posedge i_mclk);
    i_flash_sel <= 1'b0;
    chk(c_acc[2], 1'b1, "flash write strobe");
    chk(flash_cnt, f0 + 8'h01, "flash write count");
    chk(flash_addr, 16'h1234, "flash write addr");
  endtask

  // stack pointer moves up before a push and back on a pop
  task automatic test_stack();
    logic [7:0] sp;
    sp = o_stack_pointer;
    run_op(8'hc0, 8'h20, 2'h2, 4'h2);
    chk(o_stack_pointer, sp + 8'h01, "push sp");
    chk(c_ram_addr, 8'h20, "push source");
    run_op(8'hc0, 8'h21, 2'h2, 4'h2);
    chk(o_stack_pointer, sp + 8'h02, "second push sp");
    run_op(8'hd0, 8'h22, 2'h2, 4'h2);
    chk(o_stack_pointer, sp + 8'h01, "pop sp");
  endtask

  // request held while busy is not taken until the count runs out
  task automatic test_refuse();
    int k;
    @(posedge i_mclk);
    i_valid <= 1'b1;
    i_opcode <= 8'h85;
    i_operand1 <= 8'h30;
    @(posedge i_mclk);
    i_opcode <= 8'h04;
    // held request must wait out all three cycles of the move
    for (k = 1; k <= 3; k++)
    begin
      if (k > 1)
        @(posedge i_mclk);
      #1;
      chk(o_cycles, 4'h3, "held count");
      chk(o_done, k == 3, "held done");
    end
    @(posedge i_mclk);
    i_valid <= 1'b0;
    #1;
    chk(o_cycles, 4'h1, "next taken after done");
    chk(o_done, 1'b1, "one cycle done");
    @(posedge i_mclk);
  endtask

  // verdict and end of run
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (3) @(posedge i_mclk);
    i_rst <= 1'b0;
    #1;
    chk(o_stack_pointer, 8'h07, "sp reset");
    chk({o_ready, o_done, o_len}, 4'b1000, "idle after reset");
    test_table();
    test_bank();
    test_direct();
    test_access();
    test_stack();
    test_refuse();
    tally_and_finish();
  end

  // hang guard, well past the expected run
  initial
  begin
    #20000;
    mismatches++;
    $display("MISMATCH at %0t: run did not complete", $time);
    tally_and_finish();
  end
endmodule

/* File: tb/mcit_mem_model.sv */
`timescale 1ns/10ps
// far-side model: data ram, sfr space, external data space and flash
module mcit_mem_model (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // access strobes from the core
  input wire logic [15:0] i_ext_addr,
  input wire logic i_ext_wr,
  input wire logic i_flash_wr,
  input wire logic i_ram_sel,
  input wire logic i_sfr_sel,
  // access tallies for the bench
  output logic [7:0] o_flash_wr_cnt,
  output logic [7:0] o_ext_wr_cnt,
  output logic [15:0] o_last_flash_addr,
  output logic o_sel_clash
);
  // previous strobe levels, so a held strobe counts once
  logic flash_wr_d;
  logic ext_wr_d;
  // counts each new write, remembers flash target, flags ram/sfr overlap
  always @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      o_flash_wr_cnt <= 8'h00;
      o_ext_wr_cnt <= 8'h00;
      o_last_flash_addr <= 16'h0000;
      o_sel_clash <= 1'b0;
      flash_wr_d <= 1'b0;
      ext_wr_d <= 1'b0;
    end
    else
    begin
      flash_wr_d <= i_flash_wr;
      ext_wr_d <= i_ext_wr;
      // program memory write through the external move path
      if (i_flash_wr && !flash_wr_d)
      begin
        o_flash_wr_cnt <= o_flash_wr_cnt + 8'h01;
        o_last_flash_addr <= i_ext_addr;
      end
      // plain external data write
      if (i_ext_wr && !ext_wr_d)
        o_ext_wr_cnt <= o_ext_wr_cnt + 8'h01;
      // one direct address never reaches both spaces
      if (i_ram_sel && i_sfr_sel)
        o_sel_clash <= 1'b1;
    end
  end
endmodule
